// *** core/seq_tracker.sv ***
// Per-port expected packet counter with loss flag and loss count
`timescale 1ns/1ps
`include "upconv_rx_regs.svh"
module seq_tracker #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Counter check
  input wire logic check,
  input wire logic [31:0] seq_in,
  input wire logic clear,
  // Status
  output logic missing,
  output logic [CNT_W-1:0] miss_count,
  output logic [31:0] expected
);

  wire mismatch = check && (seq_in != expected);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      expected <= `SEQ_RESET;
    end else if (clear) begin
      expected <= `SEQ_RESET; // R09
    end else if (mismatch) begin
      expected <= seq_in + 32'h00000001; // R15
    end else if (check) begin
      expected <= expected + 32'h00000001; // R07
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      missing <= 1'b0;
      miss_count <= '0;
    end else begin
      // Set wins over a simultaneous stop
      missing <= mismatch || (missing && !clear); // R15
      if (mismatch) begin
        miss_count <= miss_count + CNT_W'(1); // R15
      end else if (clear) begin
        miss_count <= '0; // R09
      end
    end
  end

  property p_resync;
    @(posedge clk) disable iff (!rst_n)
    check && !clear && (seq_in != expected) |=> expected == $past(seq_in) + 32'h00000001
      && missing;
  endproperty
  a_resync: assert property (p_resync) else $error("expected count not resynced"); // R15

  property p_step;
    @(posedge clk) disable iff (!rst_n)
    check && !clear && (seq_in == expected) |=> expected == $past(expected) + 32'h00000001
      && miss_count == $past(miss_count);
  endproperty
  a_step: assert property (p_step) else $error("expected count did not step"); // R07

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
    clear && !check |=> expected == `SEQ_RESET && miss_count == '0 && !missing;
  endproperty
  a_clear: assert property (p_clear) else $error("stop did not clear tracker"); // R09

endmodule : seq_tracker

// *** core/upconv_iq_and_regwrite_rx.sv ***
// Decoder for up-converter sample packets and register-write packets
`timescale 1ns/1ps
`include "upconv_rx_regs.svh"
module upconv_iq_and_regwrite_rx
  import upconv_rx_pkg::*;
#(
  parameter int NUM_UPCONV = 2,
  parameter logic [15:0] REG_PORT_DEFAULT = 16'h0400,
  parameter int CNT_W = 16,
  localparam int NPORT = NUM_UPCONV + 1,
  localparam int SW = $clog2(NPORT),
  localparam int CW = (NUM_UPCONV > 1) ? $clog2(NUM_UPCONV) : 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Payload byte stream
  input wire logic rx_valid,
  input wire udp_beat_t rx_beat,
  input wire logic [15:0] rx_dst_port,
  input wire logic [15:0] rx_len,
  output logic rx_ready,
  // Configuration
  input wire logic [15:0] cfg_iq_port,
  input wire logic [15:0] cfg_reg_port,
  input wire logic envelope_tracking_mode,
  input wire logic envelope_restore_mode,
  input wire logic stop_cmd,
  // Up-converter samples
  output logic iq_valid,
  output logic [CW-1:0] iq_chan,
  output iq_pair_t iq_pair,
  // Envelope samples
  output logic env_valid,
  output logic [CW-1:0] env_chan,
  output iq_pair_t env_pair,
  // Register writes
  output logic reg_wr_valid,
  output reg_write_t reg_wr,
  // Sequence status
  output logic [NPORT-1:0] seq_missing,
  output logic [NPORT-1:0][CNT_W-1:0] seq_miss_count
);

  // ==========================================================
  // Reset release
  logic [1:0] rst_pipe;
  wire rst_n = rst_pipe[1];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  // ==========================================================
  // Port decode
  function automatic logic [SW-1:0] slot_of(input logic [NPORT-1:0] hits);
    logic [SW-1:0] idx;
    idx = '0;
    for (int k = NPORT - 1; k >= 0; k--) begin
      if (hits[k]) begin
        idx = SW'(k);
      end
    end
    return idx;
  endfunction : slot_of

  wire [15:0] iq_base = (cfg_iq_port == 16'h0000) ? `IQ_PORT_DEFAULT : cfg_iq_port; // R05
  wire [15:0] reg_port = (cfg_reg_port == 16'h0000) ? REG_PORT_DEFAULT : cfg_reg_port; // R13
  wire [NPORT-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < NUM_UPCONV; g++) begin : g_iq_hit
      assign hit[g] = rx_dst_port == (iq_base + 16'(g)); // R06
    end
  endgenerate
  assign hit[NUM_UPCONV] = rx_dst_port == reg_port; // R13

  // ==========================================================
  // Framing
  rx_state_t state;
  rx_state_t next_state;
  logic [10:0] byte_cnt;
  logic [2:0] ent;
  logic [7:0] pair;
  logic [SW-1:0] tgt;
  logic [47:0] shreg;

  assign rx_ready = rst_n;
  wire beat = rx_valid && rx_ready;
  wire start = beat && rx_beat.sop;
  wire full_len = rx_len >= `FULL_LEN; // R01
  wire accept = start && !rx_beat.eop && (|hit) && full_len; // R16
  wire [SW-1:0] slot = slot_of(hit);
  wire [47:0] field = {shreg[39:0], rx_beat.data}; // R14
  wire seq_done = beat && !rx_beat.sop && (state == ST_SEQ) && (byte_cnt == `SEQ_LAST); // R03
  wire emit = beat && !rx_beat.sop && (state == ST_BODY) && (ent == `ENTRY_LAST); // R04
  wire is_reg = tgt == SW'(NUM_UPCONV);
  wire env_mode = envelope_tracking_mode || envelope_restore_mode;
  wire to_env = env_mode && pair[0]; // R10

  always_comb begin
    next_state = state;
    if (start) begin
      if (rx_beat.eop) begin
        next_state = ST_IDLE;
      end else if (accept) begin
        next_state = ST_SEQ;
      end else begin
        next_state = ST_DROP; // R16
      end
    end else if (beat && rx_beat.eop) begin
      next_state = ST_IDLE;
    end else begin
      case (state)
        ST_SEQ: begin
          if (seq_done) begin
            next_state = ST_BODY; // R03
          end
        end
        ST_BODY: begin
          if (emit && (pair == `ENTRIES_LAST)) begin
            next_state = ST_DROP; // R04
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      tgt <= '0;
      shreg <= '0;
    end else begin
      state <= next_state;
      if (beat) begin
        shreg <= field;
      end
      if (accept) begin
        tgt <= slot;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_cnt <= '0;
      ent <= '0;
      pair <= '0;
    end else if (start) begin
      byte_cnt <= 11'h001;
      ent <= '0;
      pair <= '0;
    end else if (beat) begin
      byte_cnt <= byte_cnt + 11'h001;
      if (state == ST_BODY) begin
        ent <= (ent == `ENTRY_LAST) ? 3'h0 : ent + 3'h1; // R11
      end
      if (emit) begin
        pair <= pair + 8'h01;
      end
    end
  end

  // ==========================================================
  // Sample and register-write outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iq_valid <= 1'b0;
      env_valid <= 1'b0;
      reg_wr_valid <= 1'b0;
    end else begin
      iq_valid <= emit && !is_reg && !to_env; // R10
      env_valid <= emit && !is_reg && to_env; // R10
      reg_wr_valid <= emit && is_reg; // R12
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iq_chan <= '0;
      iq_pair <= '0;
      env_chan <= '0;
      env_pair <= '0;
      reg_wr <= '0;
    end else if (emit) begin
      if (is_reg) begin
        reg_wr <= field; // R12
      end else if (to_env) begin
        env_chan <= tgt[CW-1:0];
        env_pair <= field; // R02
      end else begin
        iq_chan <= tgt[CW-1:0];
        iq_pair <= field; // R02
      end
    end
  end

  // ==========================================================
  // Per-port counter trackers
  generate
    for (g = 0; g < NPORT; g++) begin : g_track
      seq_tracker #(
        .CNT_W(CNT_W)
      ) u_track (
        .clk(clk),
        .rst_n(rst_n),
        .check(seq_done && (tgt == SW'(g))), // R08
        .seq_in(field[31:0]),
        .clear(stop_cmd), // R09
        .missing(seq_missing[g]),
        .miss_count(seq_miss_count[g]),
        .expected()
      );
    end
  endgenerate

  // ==========================================================
  // Checks
  property p_short_drop;
    @(posedge clk) disable iff (!rst_n)
    start && !rx_beat.eop && (|hit) && (rx_len < `FULL_LEN) |=> state == ST_DROP
      ##1 !iq_valid && !env_valid && !reg_wr_valid;
  endproperty
  a_short_drop: assert property (p_short_drop) else $error("short packet not dropped"); // R16

  property p_default_port;
    @(posedge clk) disable iff (!rst_n)
    start && !rx_beat.eop && full_len && cfg_iq_port == 16'h0000
      && rx_dst_port == `IQ_PORT_DEFAULT && reg_port != `IQ_PORT_DEFAULT
      |=> state == ST_SEQ && tgt == '0;
  endproperty
  a_default_port: assert property (p_default_port) else $error("port 1029 not channel 0"); // R05

  property p_next_port;
    @(posedge clk) disable iff (!rst_n)
    start && !rx_beat.eop && full_len && rx_dst_port == iq_base + 16'h0001
      && reg_port != rx_dst_port |=> state == ST_SEQ && tgt == SW'(1);
  endproperty
  a_next_port: assert property (p_next_port) else $error("second channel port wrong"); // R06

  property p_seq_first;
    @(posedge clk) disable iff (!rst_n)
    state == ST_BODY && $past(state) == ST_SEQ |-> $past(byte_cnt) == `SEQ_LAST;
  endproperty
  a_seq_first: assert property (p_seq_first) else $error("payload before counter"); // R03

  property p_even_odd;
    @(posedge clk) disable iff (!rst_n)
    emit && !is_reg && env_mode |=> env_valid == $past(pair[0]) && iq_valid == !$past(pair[0]);
  endproperty
  a_even_odd: assert property (p_even_odd) else $error("envelope interleave wrong"); // R10

  property p_regwr;
    @(posedge clk) disable iff (!rst_n)
    emit && is_reg |=> reg_wr_valid && reg_wr.addr == $past(field[47:32])
      && reg_wr.data == $past(field[31:0]) && !iq_valid;
  endproperty
  a_regwr: assert property (p_regwr) else $error("register write mismatch"); // R12

  property p_entry_limit;
    @(posedge clk) disable iff (!rst_n)
    emit && pair == `ENTRIES_LAST |=> state != ST_BODY ##1 !iq_valid && !reg_wr_valid;
  endproperty
  a_entry_limit: assert property (p_entry_limit) else $error("entry past 240th"); // R11

endmodule : upconv_iq_and_regwrite_rx

// *** core/upconv_rx_pkg.sv ***
// Types shared by the up-converter sample and register-write receiver
package upconv_rx_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEQ = 2'b01,
    ST_BODY = 2'b11,
    ST_DROP = 2'b10
  } rx_state_t;

  typedef struct packed {
    logic sop;
    logic eop;
    logic [7:0] data;
  } udp_beat_t;

  typedef struct packed {
    logic signed [23:0] i;
    logic signed [23:0] q;
  } iq_pair_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] data;
  } reg_write_t;

endpackage : upconv_rx_pkg

// *** core/upconv_rx_regs.svh ***
// Offsets, defaults and sizes of the up-converter sample and register-write receiver
// Behaviour
// R01: The host sends a sample packet only when it holds a full block of 240 I/Q pairs.
// R02: Each up-converter sample is 24 bits wide and the stream runs at 192 ksps.
// R03: Bytes 0 to 3 carry a 32-bit packet counter, MSB first, taken before any payload.
// R04: From byte 4, 240 pairs of 3-byte I then 3-byte Q, MSB first, end at byte 1443.
// R05: The sample port base is configurable, and when it is zero channel 0 uses port 1029.
// R06: Each further up-converter channel listens on the previous channel's port plus one.
// R07: The packet counter starts at zero, steps by one and wraps to zero after its maximum.
// R08: Each receiving port keeps its own expected counter so losses are seen per stream.
// R09: Expected counters return to zero at start and whenever a stop command arrives.
// R10: In either envelope mode even pairs go to the up-converter and odd pairs to envelope.
// R11: A register-write payload holds 240 six-byte entries of 16-bit address, 32-bit data.
// R12: Each entry writes its 32-bit data word to the register its address selects.
// R13: The register-write port is configurable, and its zero default is a build parameter.
// R14: The host sends every multi-byte field most significant byte first.
// R15: A counter mismatch sets the port's missing flag, counts it and resyncs to count plus one.
// R16: A packet whose payload is shorter than the full size is discarded without effect.
`ifndef UPCONV_RX_REGS_SVH
`define UPCONV_RX_REGS_SVH

`define FULL_LEN 16'h05A4
`define SEQ_LAST 11'h003
`define ENTRY_LAST 3'h5
`define ENTRIES_LAST 8'hEF
`define IQ_PORT_DEFAULT 16'h0405
`define SEQ_RESET 32'h00000000

`endif

// *** sim/host_sender.sv ***
// Host model sending sample and register-write payloads
`timescale 1ns/1ps
module host_sender
  import upconv_rx_pkg::*;
(
  // Clock and ready
  input wire logic clk,
  input wire logic rx_ready,
  // Payload stream
  output logic rx_valid,
  output udp_beat_t rx_beat,
  output logic [15:0] rx_dst_port,
  output logic [15:0] rx_len
);
  initial begin
    rx_valid = 1'b0;
    rx_beat = '0;
    rx_dst_port = 16'h0000;
    rx_len = 16'h0000;
  end
  // Whole 1444-byte packet, optional idle gap after odd bytes
  task automatic send(input logic [15:0] port, input logic [15:0] len, input logic [31:0] seq,
                      input logic [7:0] salt, input logic gap);
    logic [7:0] b;
    while (rx_ready !== 1'b1) @(negedge clk);
    for (int p = 0; p < 1444; p++) begin
      @(negedge clk);
      b = (p < 4) ? seq[31-8*p -: 8] : (8'(p) ^ salt);
      rx_valid = 1'b1;
      rx_beat = '{sop: p == 0, eop: p == 1443, data: b};
      rx_dst_port = (p == 0) ? port : ~port;
      rx_len = (p == 0) ? len : ~len;
      if (gap && p[0]) begin
        @(negedge clk);
        rx_valid = 1'b0;
        rx_beat.data = ~b;
      end
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_beat = '{sop: 1'b0, eop: 1'b0, data: ~b};
  endtask : send
endmodule : host_sender

// *** sim/tb.sv ***
// Self-checking bench for the sample and register-write receiver
`timescale 1ns/1ps
module tb;
  import upconv_rx_pkg::*;
  logic clk, nrst, rx_valid, rx_ready, stop_cmd;
  logic envelope_tracking_mode, envelope_restore_mode;
  udp_beat_t rx_beat;
  logic [15:0] rx_dst_port, rx_len, cfg_iq_port, cfg_reg_port;
  logic iq_valid, env_valid, reg_wr_valid;
  logic [0:0] iq_chan, env_chan, chan;
  iq_pair_t iq_pair, env_pair;
  reg_write_t reg_wr;
  logic [2:0] seq_missing;
  logic [2:0][15:0] seq_miss_count;
  logic [7:0] salt;
  int mismatches, samples_checked, n_iq, n_env, n_reg;

  upconv_iq_and_regwrite_rx #(.NUM_UPCONV(2), .REG_PORT_DEFAULT(16'h0400), .CNT_W(16)) DUT (
    .clk(clk), .nrst(nrst), .rx_valid(rx_valid), .rx_beat(rx_beat),
    .rx_dst_port(rx_dst_port), .rx_len(rx_len), .rx_ready(rx_ready),
    .cfg_iq_port(cfg_iq_port), .cfg_reg_port(cfg_reg_port),
    .envelope_tracking_mode(envelope_tracking_mode),
    .envelope_restore_mode(envelope_restore_mode), .stop_cmd(stop_cmd),
    .iq_valid(iq_valid), .iq_chan(iq_chan), .iq_pair(iq_pair), .env_valid(env_valid),
    .env_chan(env_chan), .env_pair(env_pair), .reg_wr_valid(reg_wr_valid), .reg_wr(reg_wr),
    .seq_missing(seq_missing), .seq_miss_count(seq_miss_count));

  host_sender HOST (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_beat(rx_beat),
    .rx_dst_port(rx_dst_port), .rx_len(rx_len));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================
  // Checking helpers
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // Six payload bytes of entry k, MSB first
  function automatic logic [47:0] e48(input int k);
    logic [47:0] v;
    v = '0;
    for (int j = 0; j < 6; j++) v = {v[39:0], 8'(4 + 6*k + j) ^ salt};
    return v;
  endfunction : e48

  always @(negedge clk) begin
    if (iq_valid === 1'b1) begin
      chk("iq_chan", chan, iq_chan);
      chk("iq_pair", e48((envelope_tracking_mode | envelope_restore_mode) ? 2*n_iq : n_iq),
          iq_pair);
      n_iq++;
    end
    if (env_valid === 1'b1) begin
      chk("env_chan", chan, env_chan);
      chk("env_pair", e48(2*n_env + 1), env_pair);
      n_env++;
    end
    if (reg_wr_valid === 1'b1) begin
      chk("reg_wr", e48(n_reg), reg_wr);
      n_reg++;
    end
  end

  task automatic pkt(input logic [15:0] port, input logic [15:0] len, input logic [31:0] seq,
                     input logic [7:0] s, input logic gap, input int ni, input int ne, input int nr);
    salt = s;
    n_iq = 0;
    n_env = 0;
    n_reg = 0;
    HOST.send(port, len, seq, s, gap);
    repeat (4) @(negedge clk);
    chk("n_iq", ni, n_iq);
    chk("n_env", ne, n_env);
    chk("n_reg", nr, n_reg);
  endtask : pkt

  task automatic status(input logic [2:0] m, input logic [15:0] c0, input logic [15:0] c1);
    chk("seq_missing", m, seq_missing);
    chk("miss_count0", c0, seq_miss_count[0]);
    chk("miss_count1", c1, seq_miss_count[1]);
    chk("miss_count2", 16'h0000, seq_miss_count[2]);
  endtask : status

  // ==========================================
  // Scenarios
  task automatic t_iq;
    chan = 1'b0;
    pkt(16'h0405, 16'h05A4, 32'h0, 8'h5A, 1'b0, 240, 0, 0);
    pkt(16'h0405, 16'h05A4, 32'h1, 8'hA5, 1'b1, 240, 0, 0);
    status(3'b000, 16'h0, 16'h0);
    chan = 1'b1;
    pkt(16'h0406, 16'h05A4, 32'h0, 8'hC3, 1'b0, 240, 0, 0);
    status(3'b000, 16'h0, 16'h0);
  endtask : t_iq

  task automatic t_reg;
    pkt(16'h0400, 16'h05A4, 32'h0, 8'h3C, 1'b0, 0, 0, 240);
    cfg_reg_port = 16'h2222;
    cfg_iq_port = 16'h1100;
    pkt(16'h2222, 16'h05A4, 32'h1, 8'h96, 1'b0, 0, 0, 240);
    chan = 1'b0;
    pkt(16'h1100, 16'h05A4, 32'h2, 8'h69, 1'b0, 240, 0, 0);
    pkt(16'h0405, 16'h05A4, 32'h3, 8'h5C, 1'b0, 0, 0, 0);
    cfg_reg_port = 16'h0000;
    cfg_iq_port = 16'h0000;
    status(3'b000, 16'h0, 16'h0);
  endtask : t_reg

  task automatic t_short_loss;
    pkt(16'h0405, 16'h05A3, 32'h7, 8'h11, 1'b0, 0, 0, 0);
    status(3'b000, 16'h0, 16'h0);
    pkt(16'h0405, 16'h05A4, 32'h9, 8'h22, 1'b0, 240, 0, 0);
    status(3'b001, 16'h1, 16'h0);
    pkt(16'h0405, 16'h05A4, 32'hA, 8'h33, 1'b0, 240, 0, 0);
    pkt(16'h0405, 16'h05A4, 32'hFFFFFFFE, 8'h44, 1'b0, 240, 0, 0);
    pkt(16'h0405, 16'h05A4, 32'hFFFFFFFF, 8'h4B, 1'b0, 240, 0, 0);
    pkt(16'h0405, 16'h05A4, 32'h0, 8'h55, 1'b0, 240, 0, 0);
    status(3'b001, 16'h2, 16'h0);
  endtask : t_short_loss

  task automatic t_env;
    envelope_tracking_mode = 1'b1;
    pkt(16'h0405, 16'h05A4, 32'h1, 8'h77, 1'b0, 120, 120, 0);
    envelope_tracking_mode = 1'b0;
    envelope_restore_mode = 1'b1;
    pkt(16'h0405, 16'h05A4, 32'h2, 8'h88, 1'b1, 120, 120, 0);
    envelope_restore_mode = 1'b0;
  endtask : t_env

  task automatic t_stop;
    pkt(16'h0400, 16'h05A4, 32'h5, 8'hD2, 1'b0, 0, 0, 240);
    chk("seq_missing", 3'b101, seq_missing);
    chk("miss_count2", 16'h0001, seq_miss_count[2]);
    @(negedge clk);
    stop_cmd = 1'b1;
    @(negedge clk);
    stop_cmd = 1'b0;
    repeat (2) @(negedge clk);
    status(3'b000, 16'h0, 16'h0);
    pkt(16'h0405, 16'h05A4, 32'h0, 8'h99, 1'b0, 240, 0, 0);
    pkt(16'h0400, 16'h05A4, 32'h0, 8'hE1, 1'b0, 0, 0, 240);
    status(3'b000, 16'h0, 16'h0);
  endtask : t_stop

  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  initial begin
    #(25 * 60000);
    mismatches++;
    test_done();
  end

  initial begin
    nrst = 1'b0;
    stop_cmd = 1'b0;
    envelope_tracking_mode = 1'b0;
    envelope_restore_mode = 1'b0;
    cfg_iq_port = 16'h0000;
    cfg_reg_port = 16'h0000;
    chan = 1'b0;
    salt = 8'h00;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    t_iq();
    t_reg();
    t_short_loss();
    t_env();
    t_stop();
    test_done();
  end
endmodule : tb
